// File: qwp_core.sv
// Quadrant write-protect command decoder for a serial EEPROM link
// Assumes scl and sda arrive raw from the pins; scl clocks the link logic
`timescale 1ns/1ps
`default_nettype none
module qwp_core (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic hv_select_pin,
    input wire logic strap_pin_mid,
    input wire logic strap_pin_high,
    output logic [3:0] quadrant_protect,
    output logic cmd_busy
);
    import qwp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Quadrant code decode, used for set and read
    function automatic logic [4:0] qwp_decode(input logic [2:0] code);
        // Low four bits one-hot quadrant, bit 4 marks a valid code
        case (code)
            QWP_CODE_Q0: qwp_decode = 5'h11;
            QWP_CODE_Q1: qwp_decode = 5'h12;
            QWP_CODE_Q2: qwp_decode = 5'h14;
            QWP_CODE_Q3: qwp_decode = 5'h18;
            default: qwp_decode = 5'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link domain on scl: bit capture, ack drive
    typedef struct packed {
        qwp_state_type state;
        logic [3:0] bits;
        logic [7:0] shift;
        qwp_cmd_type cmd;
        logic [3:0] target;
        logic [1:0] body_cnt;
        logic ack;
        logic done_tgl;
        qwp_cmd_type done_cmd;
        logic [3:0] done_target;
        logic busy;
    } qwp_link_type;
    qwp_link_type l_reg;
    qwp_link_type l_next;

    // Start seen on a falling sda edge while scl high
    logic start_tgl_reg;
    logic start_seen;
    logic [3:0] prot_link_sync1_reg;
    logic [3:0] prot_link_reg;
    logic hv_link_sync1_reg;
    logic hv_link_reg;
    logic [7:0] shifted;
    logic [4:0] dec;

    // Link side has no clock at rest, so srst clears it asynchronously
    always_ff @(negedge sda_in or posedge srst) begin
        if (srst) begin
            start_tgl_reg <= 1'b0;
        end else if (scl) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    // Protection state and high voltage flag brought into the link domain
    always_ff @(posedge scl) begin
        prot_link_sync1_reg <= quadrant_protect;
        prot_link_reg <= prot_link_sync1_reg;
        hv_link_sync1_reg <= hv_select_pin;
        hv_link_reg <= hv_link_sync1_reg;
    end

    // Start observed since last scl edge
    logic start_ref_reg;
    always_ff @(posedge scl or posedge srst) begin
        if (srst) begin
            start_ref_reg <= 1'b0;
        end else begin
            start_ref_reg <= start_tgl_reg;
        end
    end
    assign start_seen = start_ref_reg ^ start_tgl_reg;

    // Byte framing and command decode; strap pins never looked at
    always_comb begin
        l_next = l_reg;
        shifted = {l_reg.shift[6:0], sda_in};
        dec = qwp_decode(shifted[QWP_CODE_MSB:QWP_CODE_LSB]);
        if (start_seen) begin
            l_next.state = QWP_CTRL;
            l_next.bits = 4'h1;
            l_next.shift = {7'h00, sda_in};
            l_next.ack = 1'b0;
        end else begin
            case (l_reg.state)
                QWP_CTRL: begin
                    l_next.shift = shifted;
                    l_next.bits = l_reg.bits + 4'h1;
                    if (l_reg.bits == QWP_BYTE_BITS - 4'h1) begin
                        l_next.state = QWP_ACK;
                        l_next.cmd = QWP_CMD_NONE;
                        l_next.ack = 1'b0;
                        l_next.target = dec[3:0];
                        if (shifted[QWP_TYPE_MSB:QWP_TYPE_LSB] == QWP_PROT_TYPE) begin
                            if (shifted[QWP_DIR_BIT]) begin
                                l_next.cmd = QWP_CMD_READ;
                                l_next.ack = dec[4] && ((prot_link_reg & dec[3:0]) == 4'h0);
                            end else if (!hv_link_reg) begin
                                l_next.cmd = QWP_CMD_NONE;
                            end else if (shifted[QWP_CODE_MSB:QWP_CODE_LSB] == QWP_CODE_CLEAR) begin
                                l_next.cmd = QWP_CMD_CLEAR;
                                l_next.ack = 1'b1;
                            end else if (dec[4] && ((prot_link_reg & dec[3:0]) == 4'h0)) begin
                                l_next.cmd = QWP_CMD_SET;
                                l_next.ack = 1'b1;
                            end
                        end
                    end
                end
                QWP_ACK: begin
                    l_next.ack = 1'b0;
                    l_next.bits = 4'h0;
                    l_next.body_cnt = 2'h0;
                    l_next.state = (l_reg.cmd == QWP_CMD_NONE) ? QWP_IGNORE : QWP_BODY;
                end
                QWP_BODY: begin
                    l_next.bits = l_reg.bits + 4'h1;
                    l_next.ack = 1'b0;
                    if (l_reg.bits == QWP_BYTE_BITS - 4'h1) begin
                        // Ack address and data of set and clear; read acks neither
                        l_next.ack = (l_reg.cmd != QWP_CMD_READ);
                    end
                    if (l_reg.bits == QWP_BYTE_BITS) begin
                        l_next.bits = 4'h0;
                        l_next.body_cnt = l_reg.body_cnt + 2'h1;
                        if (l_reg.body_cnt == 2'h1) begin
                            // Command committed after data byte, hv still required
                            if (l_reg.cmd != QWP_CMD_READ && hv_link_reg) begin
                                l_next.done_tgl = ~l_reg.done_tgl;
                                l_next.done_cmd = l_reg.cmd;
                                l_next.done_target = l_reg.target;
                            end
                            l_next.state = QWP_IGNORE;
                        end
                    end
                end
                QWP_IGNORE: l_next.ack = 1'b0;
                default: l_next.state = QWP_IDLE;
            endcase
        end
        // Framing flag kept as one bit so it can be synchronised
        l_next.busy = (l_next.state == QWP_CTRL) || (l_next.state == QWP_ACK) ||
            (l_next.state == QWP_BODY);
    end

    always_ff @(posedge scl or posedge srst) begin
        if (srst) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // Ack is driven while scl low after the eighth bit
    logic ack_drive_reg;
    always_ff @(negedge scl or posedge srst) begin
        if (srst) begin
            ack_drive_reg <= 1'b0;
        end else begin
            ack_drive_reg <= l_reg.ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: protection bits updated from link events
    typedef struct packed {
        logic [2:0] tgl_pipe;
        logic [3:0] prot;
        logic busy;
        logic sda_out;
        logic sda_oe;
    } qwp_sys_type;
    qwp_sys_type s_reg;
    qwp_sys_type s_next;
    logic done_sync;
    logic ack_sync;
    logic busy_sync;

    qwp_sync u_done_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in(l_reg.done_tgl),
        .sync_out(done_sync)
    );

    qwp_sync u_ack_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in(ack_drive_reg),
        .sync_out(ack_sync)
    );

    qwp_sync u_busy_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in(l_reg.busy),
        .sync_out(busy_sync)
    );

    // Command words are stable long before the toggle reaches here
    always_comb begin
        s_next = s_reg;
        s_next.tgl_pipe = {s_reg.tgl_pipe[1:0], done_sync};
        s_next.busy = busy_sync || (done_sync ^ s_reg.tgl_pipe[2]); // Held until commit lands
        s_next.sda_out = 1'b0;
        s_next.sda_oe = ack_sync;
        if (s_reg.tgl_pipe[1] ^ s_reg.tgl_pipe[2]) begin
            if (l_reg.done_cmd == QWP_CMD_SET) begin
                s_next.prot = s_reg.prot | l_reg.done_target;
            end else if (l_reg.done_cmd == QWP_CMD_CLEAR) begin
                s_next.prot = QWP_PROT_RESET;
            end
        end
        if (srst) begin
            s_next = '0;
            s_next.prot = QWP_PROT_RESET;
        end
    end

    always_ff @(posedge sys_clk) begin
        s_reg <= s_next;
    end

    assign quadrant_protect = s_reg.prot;
    assign cmd_busy = s_reg.busy;
    assign sda_out = s_reg.sda_out;
    assign sda_oe = s_reg.sda_oe;
endmodule
`default_nettype wire

// File: qwp_core_chk.sv
// Port checker for the quadrant write-protect command logic
// Assumes it is bound onto qwp_core in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module qwp_core_chk (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hv_select_pin,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [3:0] quadrant_protect,
    input wire logic cmd_busy
);
    logic [4:0] oe_cnt_reg;
    // Length of the current acknowledge
    always_ff @(posedge sys_clk) begin
        if (srst || !sda_oe) begin
            oe_cnt_reg <= 5'h0;
        end else if (oe_cnt_reg != 5'h1f) begin
            oe_cnt_reg <= oe_cnt_reg + 5'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    // Assertions
    AST_OPEN_DRAIN: assert property (!sda_out)
        else $error("sda_out driven high");
    AST_CLEAR_ALL: assert property (
        |($past(quadrant_protect) & ~quadrant_protect) |-> quadrant_protect == 4'h0)
        else $error("protection cleared partly");
    AST_ONE_SET: assert property (
        $countones(quadrant_protect & ~$past(quadrant_protect)) <= 1)
        else $error("several quadrants set at once");
    AST_HV_GATE: assert property (
        $changed(quadrant_protect) |-> hv_select_pin && $past(hv_select_pin, 4))
        else $error("protection changed without hv flag");
    AST_CHANGE_BUSY: assert property ($changed(quadrant_protect) |-> $past(cmd_busy))
        else $error("protection changed outside a command");
    AST_ACK_BUSY: assert property ($rose(sda_oe) |-> cmd_busy)
        else $error("ack outside a command");
    AST_ACK_LEN: assert property (oe_cnt_reg < 5'h14)
        else $error("ack held too long");
    AST_RESET_CLR: assert property ($past(srst) |-> quadrant_protect == 4'h0 && !sda_oe)
        else $error("outputs not cleared by reset");
endmodule
bind qwp_core qwp_core_chk chk (.sys_clk(sys_clk), .srst(srst),
    .hv_select_pin(hv_select_pin), .sda_out(sda_out), .sda_oe(sda_oe),
    .quadrant_protect(quadrant_protect), .cmd_busy(cmd_busy));
`default_nettype wire

// File: qwp_master.sv
// Serial bus master model driving the link
// Assumes sda_wire is the resolved pulled-up data line
`timescale 1ns/1ps
`default_nettype none
module qwp_master (
    output logic scl,
    output logic sda_m,
    input wire logic sda_wire
);
    // Clock and data stand high between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // One byte MSB first, then the ack slot with a stretched low phase
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_m = b[i];
            #20 scl = 1'b1;
            #40 scl = 1'b0;
        end
        #20 sda_m = 1'b1;
        #200 ack = ~sda_wire;
        scl = 1'b1;
        #40 scl = 1'b0;
        #200;
    endtask
    // Start, control, address and data bytes, stop
    task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
        output logic [2:0] acks);
        #100 sda_m = 1'b0;
        #100 scl = 1'b0;
        send_byte(c, acks[2]);
        send_byte(a, acks[1]);
        send_byte(d, acks[0]);
        #20 sda_m = 1'b0;
        #40 scl = 1'b1;
        #100 sda_m = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// File: qwp_pkg.sv
// Constants for the quadrant write-protect command logic
// Assumes one system clock domain plus the serial clock domain of the link
package qwp_pkg;
    // Control byte fields
    localparam logic [3:0] QWP_PROT_TYPE = 4'h6;
    localparam int QWP_TYPE_MSB = 7;
    localparam int QWP_TYPE_LSB = 4;
    localparam int QWP_CODE_MSB = 3;
    localparam int QWP_CODE_LSB = 1;
    localparam int QWP_DIR_BIT = 0;
    // Quadrant codes
    localparam logic [2:0] QWP_CODE_Q0 = 3'h1;
    localparam logic [2:0] QWP_CODE_Q1 = 3'h4;
    localparam logic [2:0] QWP_CODE_Q2 = 3'h5;
    localparam logic [2:0] QWP_CODE_Q3 = 3'h0;
    localparam logic [2:0] QWP_CODE_CLEAR = 3'h3;
    localparam int QWP_QUADS = 4;
    localparam logic [3:0] QWP_PROT_RESET = 4'h0;
    // Bits per byte on the link
    localparam logic [3:0] QWP_BYTE_BITS = 4'h8;
    // Link state machine, gray along the usual path
    typedef enum logic [2:0] {
        QWP_IDLE = 3'b000,
        QWP_CTRL = 3'b001,
        QWP_ACK = 3'b011,
        QWP_BODY = 3'b010,
        QWP_IGNORE = 3'b110
    } qwp_state_type;
    // Command classes
    typedef enum logic [1:0] {
        QWP_CMD_NONE = 2'h0,
        QWP_CMD_SET = 2'h1,
        QWP_CMD_CLEAR = 2'h2,
        QWP_CMD_READ = 2'h3
    } qwp_cmd_type;
endpackage

// File: qwp_sync.sv
// Two-flop synchroniser for a level into the system clock domain
// Assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module qwp_sync (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);
    import qwp_pkg::*;
    typedef struct packed {
        logic first;
        logic second;
    } qwp_sync_type;
    qwp_sync_type s_reg;
    qwp_sync_type s_next;

    // First flop feeds only the second
    always_comb begin
        s_next.first = async_in;
        s_next.second = s_reg.first;
        if (srst) begin
            s_next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        s_reg <= s_next;
    end

    assign sync_out = s_reg.second;
endmodule
`default_nettype wire

// File: tb_quadrant_write_protect_cmds.sv
// Bench for the quadrant write-protect command logic
// Assumes qwp_master plays the bus master on the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_quadrant_write_protect_cmds;
    import qwp_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b0;
    logic hv_select_pin = 1'b0;
    logic strap_pin_mid = 1'b0;
    logic strap_pin_high = 1'b0;
    logic scl, sda_m, sda_out, sda_oe, cmd_busy;
    logic [3:0] quadrant_protect;
    logic [2:0] acks;
    logic [2:0] codes [4] = '{QWP_CODE_Q0, QWP_CODE_Q1, QWP_CODE_Q2, QWP_CODE_Q3};
    int miscompares = 0;
    int compares = 0;
    wire logic sda_wire = sda_m & ~sda_oe;
    always #20 sys_clk = ~sys_clk;
    qwp_core dut (.sys_clk(sys_clk), .srst(srst), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .hv_select_pin(hv_select_pin),
        .strap_pin_mid(strap_pin_mid), .strap_pin_high(strap_pin_high),
        .quadrant_protect(quadrant_protect), .cmd_busy(cmd_busy));
    qwp_master m (.scl(scl), .sda_m(sda_m), .sda_wire(sda_wire));
    ////////////////////////////////////////////////////////////////
    // One transaction; hv held over all of it, straps wander
    task automatic run(input logic [7:0] c, input logic hv);
        @(posedge sys_clk);
        #1 hv_select_pin = hv;
        strap_pin_mid = ~strap_pin_mid;
        strap_pin_high = c[1];
        fork
            m.xfer(c, 8'h5a, 8'ha5, acks);
            begin
                // At the last bit of the control byte every command is being framed
                repeat (20) @(posedge sys_clk);
                #1 `CHK(cmd_busy, 1'b1)
            end
        join
        repeat (4) @(posedge sys_clk);
        #1 hv_select_pin = 1'b0;
        `CHK(cmd_busy, 1'b0)
    endtask
    // Protect each quadrant in turn, then read all back
    task automatic t_set_all;
        logic [3:0] exp;
        exp = 4'h0;
        for (int i = 0; i < QWP_QUADS; i++) begin
            run({QWP_PROT_TYPE, codes[i], 1'b0}, 1'b1);
            exp[i] = 1'b1;
            `CHK(acks, 3'h7)
            `CHK(quadrant_protect, exp)
        end
        for (int i = 0; i < QWP_QUADS; i++) begin
            run({QWP_PROT_TYPE, codes[i], 1'b1}, 1'b0);
            `CHK(acks, 3'h0)
        end
        $display("t_set_all done");
    endtask
    // Repeat set, bad code and clear without hv
    task automatic t_refused;
        run({QWP_PROT_TYPE, QWP_CODE_Q1, 1'b0}, 1'b1);
        `CHK(acks, 3'h0)
        run({QWP_PROT_TYPE, 3'h2, 1'b0}, 1'b1);
        `CHK(acks, 3'h0)
        run({QWP_PROT_TYPE, QWP_CODE_CLEAR, 1'b0}, 1'b0);
        `CHK(acks, 3'h0)
        `CHK(quadrant_protect, 4'hf)
        $display("t_refused done");
    endtask
    // Clear all, read back unprotected, set without hv
    task automatic t_clear;
        run({QWP_PROT_TYPE, QWP_CODE_CLEAR, 1'b0}, 1'b1);
        `CHK(acks, 3'h7)
        `CHK(quadrant_protect, 4'h0)
        for (int i = 0; i < QWP_QUADS; i++) begin
            run({QWP_PROT_TYPE, codes[i], 1'b1}, 1'b1);
            `CHK(acks, 3'h4)
        end
        run({QWP_PROT_TYPE, QWP_CODE_Q2, 1'b0}, 1'b0);
        `CHK(acks, 3'h0)
        `CHK(quadrant_protect, 4'h0)
        $display("t_clear done");
    endtask
    // Counts and verdict
    task automatic give_verdict;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        // Raised after time zero so the link side sees a reset edge
        #1 srst = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge sys_clk);
        t_set_all();
        t_refused();
        t_clear();
        give_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
